// file: vdt_cfg.svh
// Purpose: constants for the dual-port video dram transfer block
// Assumes: core clock of 200 MHz
// Notes: offsets none; pins only
`ifndef VDT_CFG_SVH
`define VDT_CFG_SVH
`define VDT_ROWS 256
`define VDT_WORDS 256
`define VDT_ADDR_W 8
`define VDT_DATA_W 4
`define VDT_CLK_PERIOD_PS 5000
`define VDT_CLZ_DELAY_PS 5000
`define VDT_CLZ_CYCLES ((`VDT_CLZ_DELAY_PS + `VDT_CLK_PERIOD_PS - 1) / `VDT_CLK_PERIOD_PS)
`define VDT_SCA_DELAY_PS 5000
`define VDT_SCA_CYCLES ((`VDT_SCA_DELAY_PS + `VDT_CLK_PERIOD_PS - 1) / `VDT_CLK_PERIOD_PS)
`define VDT_REFCNT_RESET 8'h00
`define VDT_PTR_RESET 8'h00
`endif

// file: vdt_pkg.sv
// Purpose: types for the dual-port video dram transfer block
// Assumes: nothing
// Notes: constants live in vdt_cfg.svh
package vdt_pkg;
    typedef enum logic [2:0]
    {
        VDT_IDLE = 3'h0,
        VDT_ACCESS = 3'h1,
        VDT_XFER = 3'h3,
        VDT_REFRESH = 3'h2
    } vdt_state_e;
    typedef enum logic [1:0]
    {
        VDT_X_READ = 2'h0,
        VDT_X_WRITE = 2'h1,
        VDT_X_PSEUDO = 2'h2,
        VDT_X_NONE = 2'h3
    } vdt_xfer_e;
    typedef struct packed
    {
        logic rowStrobeN;
        logic colStrobeN;
        logic transferOutputEnableN;
        logic maskWriteEnableN;
        logic serialPortEnableN;
        logic serialShiftClock;
        logic [7:0] addr;
        logic [3:0] maskDataIn;
        logic [3:0] serialDataIn;
    } vdt_pins_s;
endpackage

// file: vdt_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: pins are asynchronous to core_clk
// Notes: first stage read only by second
`timescale 1ns/1ps
module vdt_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_reg <= '1;
            q_reg <= '1;
        end
        else
        begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end
    assign q = q_reg;
endmodule

// file: vdt_serial.sv
// Purpose: circular serial buffer pointer and shift datapath
// Assumes: shift enable is a one-cycle pulse per serial clock rise
// Notes: buffer storage lives in the top module
`timescale 1ns/1ps
`include "vdt_cfg.svh"
module vdt_serial (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic shiftPulse,
    input wire logic loadPtr,
    input wire logic [7:0] loadVal,
    output logic [7:0] ptr
);
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;
    always_comb
    begin
        ptr_next = ptr_reg;
        if (loadPtr)
        begin
            ptr_next = loadVal;
        end
        else if (shiftPulse)
        begin
            ptr_next = ptr_reg + 8'h01;
        end
    end
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ptr_reg <= `VDT_PTR_RESET;
        end
        else
        begin
            ptr_reg <= ptr_next;
        end
    end
    assign ptr = ptr_reg;
endmodule

// file: vdt_top.sv
// Purpose: dual-port video dram core with transfer, refresh and serial port
// Assumes: pins sampled on core_clk at 200 MHz; array rows are 1024 bits
// Notes: refresh is modelled as a row touch; cells hold without decay
`timescale 1ns/1ps
`include "vdt_cfg.svh"
module vdt_top (
    input wire logic core_clk,
    input wire logic nrst,
    input wire vdt_pkg::vdt_pins_s pinsIn,
    input wire logic [3:0] writeDataIn,
    output logic [3:0] maskDataOut,
    output logic maskDataOe,
    output logic [3:0] serialDataOut,
    output logic serialDataOe,
    output logic [7:0] refreshRow,
    output logic refreshPulse
);
    vdt_pkg::vdt_pins_s pins;
    logic [3:0] wdata;
    logic [3:0] wdataMeta;
    logic [3:0] wdata_reg;
    vdt_sync #(.W($bits(vdt_pkg::vdt_pins_s))) u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .d(pinsIn),
        .q(pins)
    );
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wdataMeta <= 4'h0;
            wdata_reg <= 4'h0;
        end
        else
        begin
            wdataMeta <= writeDataIn;
            wdata_reg <= wdataMeta;
        end
    end
    assign wdata = wdata_reg;

    // memories: word-major so each generate lane owns its own slice
    logic [3:0] array [0:`VDT_WORDS-1][0:`VDT_ROWS-1];
    logic [3:0] sbuf [0:`VDT_WORDS-1];

    // edge detection on synchronised pins
    logic rasD_reg, casD_reg, oeD_reg, scD_reg;
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rasD_reg <= 1'b1;
            casD_reg <= 1'b1;
            oeD_reg <= 1'b1;
            // synchroniser resets high, so no false clock rise
            scD_reg <= 1'b1;
        end
        else
        begin
            rasD_reg <= pins.rowStrobeN;
            casD_reg <= pins.colStrobeN;
            oeD_reg <= pins.transferOutputEnableN;
            scD_reg <= pins.serialShiftClock;
        end
    end
    logic rasFall, casFall, casRise, oeRise, scRise;
    assign rasFall = rasD_reg & ~pins.rowStrobeN;
    assign casFall = casD_reg & ~pins.colStrobeN;
    assign casRise = ~casD_reg & pins.colStrobeN;
    assign oeRise = ~oeD_reg & pins.transferOutputEnableN;
    assign scRise = ~scD_reg & pins.serialShiftClock;

    // serial pointer
    logic [7:0] ptr;
    logic loadPtr;
    vdt_serial u_serial (
        .core_clk(core_clk),
        .nrst(nrst),
        .shiftPulse(scRise),
        .loadPtr(loadPtr),
        .loadVal(pins.addr),
        .ptr(ptr)
    );

    // control state
    vdt_pkg::vdt_state_e state_reg, state_next;
    vdt_pkg::vdt_xfer_e xfer_reg, xfer_next;
    logic [7:0] row_reg, row_next;
    logic [7:0] refCnt_reg, refCnt_next;
    logic [3:0] mask_reg, mask_next;
    logic maskEn_reg, maskEn_next;
    logic serOut_reg, serOut_next;
    logic [7:0] clz_reg, clz_next;
    logic [3:0] rdata_reg, rdata_next;
    logic dqOe_reg, dqOe_next;
    logic readCyc_reg, readCyc_next;
    logic [7:0] refRow_reg, refRow_next;
    logic refPulse_reg, refPulse_next;
    logic doReadXfer, doWriteXfer, doArrayWrite;
    logic [7:0] col_reg, col_next;

    always_comb
    begin
        state_next = state_reg;
        xfer_next = xfer_reg;
        row_next = row_reg;
        refCnt_next = refCnt_reg;
        mask_next = mask_reg;
        maskEn_next = maskEn_reg;
        serOut_next = serOut_reg;
        clz_next = clz_reg;
        rdata_next = rdata_reg;
        dqOe_next = dqOe_reg;
        readCyc_next = readCyc_reg;
        refRow_next = refRow_reg;
        refPulse_next = 1'b0;
        col_next = col_reg;
        loadPtr = 1'b0;
        doReadXfer = 1'b0;
        doWriteXfer = 1'b0;
        doArrayWrite = 1'b0;
        if (rasFall)
        begin
            if (pins.colStrobeN == 1'b0)
            begin
                state_next = vdt_pkg::VDT_REFRESH;
                refRow_next = refCnt_reg;
                refCnt_next = refCnt_reg + 8'h01;
                refPulse_next = 1'b1;
            end
            else
            begin
                row_next = pins.addr;
                refRow_next = pins.addr;
                refPulse_next = 1'b1;
                maskEn_next = ~pins.maskWriteEnableN;
                mask_next = pins.maskDataIn;
                if (!pins.transferOutputEnableN)
                begin
                    state_next = vdt_pkg::VDT_XFER;
                    if (pins.maskWriteEnableN)
                    begin
                        xfer_next = vdt_pkg::VDT_X_READ;
                    end
                    else if (!pins.serialPortEnableN)
                    begin
                        xfer_next = vdt_pkg::VDT_X_WRITE;
                    end
                    else
                    begin
                        xfer_next = vdt_pkg::VDT_X_PSEUDO;
                    end
                end
                else
                begin
                    state_next = vdt_pkg::VDT_ACCESS;
                    xfer_next = vdt_pkg::VDT_X_NONE;
                end
            end
        end
        if (casFall && state_reg != vdt_pkg::VDT_REFRESH)
        begin
            col_next = pins.addr;
            if (state_reg == vdt_pkg::VDT_XFER && xfer_reg != vdt_pkg::VDT_X_PSEUDO)
            begin
                loadPtr = 1'b1;
            end
            if (state_reg == vdt_pkg::VDT_ACCESS)
            begin
                readCyc_next = pins.maskWriteEnableN;
                clz_next = 8'(`VDT_CLZ_CYCLES);
                rdata_next = array[pins.addr][row_reg];
                if (!pins.maskWriteEnableN)
                begin
                    doArrayWrite = 1'b1;
                end
            end
        end
        if (clz_reg != 8'h00)
        begin
            clz_next = clz_reg - 8'h01;
            if (clz_reg == 8'h01 && readCyc_reg)
            begin
                dqOe_next = 1'b1;
            end
        end
        if (pins.colStrobeN || casRise)
        begin
            dqOe_next = 1'b0;
            readCyc_next = 1'b0;
            clz_next = 8'h00;
        end
        else if (pins.transferOutputEnableN)
        begin
            dqOe_next = 1'b0;
        end
        else if (readCyc_reg && clz_reg == 8'h00)
        begin
            dqOe_next = 1'b1;
        end
        if (state_reg == vdt_pkg::VDT_XFER && oeRise)
        begin
            case (xfer_reg)
                vdt_pkg::VDT_X_READ:
                begin
                    doReadXfer = 1'b1;
                    serOut_next = 1'b1;
                end
                vdt_pkg::VDT_X_WRITE:
                begin
                    doWriteXfer = 1'b1;
                    serOut_next = 1'b0;
                end
                vdt_pkg::VDT_X_PSEUDO:
                begin
                    serOut_next = 1'b0;
                end
                default:
                begin
                    serOut_next = serOut_reg;
                end
            endcase
            state_next = vdt_pkg::VDT_ACCESS;
        end
        if (pins.rowStrobeN && pins.colStrobeN && !rasFall)
        begin
            state_next = vdt_pkg::VDT_IDLE;
            maskEn_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= vdt_pkg::VDT_IDLE;
            xfer_reg <= vdt_pkg::VDT_X_NONE;
            row_reg <= 8'h00;
            refCnt_reg <= `VDT_REFCNT_RESET;
            mask_reg <= 4'hf;
            maskEn_reg <= 1'b0;
            serOut_reg <= 1'b0;
            clz_reg <= 8'h00;
            rdata_reg <= 4'h0;
            dqOe_reg <= 1'b0;
            readCyc_reg <= 1'b0;
            refRow_reg <= 8'h00;
            refPulse_reg <= 1'b0;
            col_reg <= 8'h00;
        end
        else
        begin
            state_reg <= state_next;
            xfer_reg <= xfer_next;
            row_reg <= row_next;
            refCnt_reg <= refCnt_next;
            mask_reg <= mask_next;
            maskEn_reg <= maskEn_next;
            serOut_reg <= serOut_next;
            clz_reg <= clz_next;
            rdata_reg <= rdata_next;
            dqOe_reg <= dqOe_next;
            readCyc_reg <= readCyc_next;
            refRow_reg <= refRow_next;
            refPulse_reg <= refPulse_next;
            col_reg <= col_next;
        end
    end

    // memory writes, one generate lane per word; no reset on storage
    logic [3:0] serOutData_reg;
    logic serOe_reg;
    genvar gi;
    generate
        for (gi = 0; gi < `VDT_WORDS; gi++)
        begin : g_word
            always_ff @(posedge core_clk)
            begin
                if (doReadXfer)
                begin
                    sbuf[gi] <= array[gi][row_reg];
                end
                else if (scRise && !serOut_reg && !pins.serialPortEnableN && ptr == 8'(gi))
                begin
                    sbuf[gi] <= pins.serialDataIn;
                end
                if (doWriteXfer)
                begin
                    array[gi][row_reg] <= sbuf[gi];
                end
                else if (doArrayWrite && pins.addr == 8'(gi))
                begin
                    array[gi][row_reg] <= maskEn_reg ?
                        ((wdata & mask_reg) | (array[gi][row_reg] & ~mask_reg)) : wdata;
                end
            end
        end
    endgenerate

    // new word only after a serial clock rise
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            serOutData_reg <= 4'h0;
            serOe_reg <= 1'b0;
        end
        else
        begin
            if (scRise && serOut_reg)
            begin
                serOutData_reg <= sbuf[ptr];
            end
            serOe_reg <= serOut_reg & ~pins.serialPortEnableN;
        end
    end

    assign maskDataOut = rdata_reg;
    assign maskDataOe = dqOe_reg;
    assign serialDataOut = serOutData_reg;
    assign serialDataOe = serOe_reg;
    assign refreshRow = refRow_reg;
    assign refreshPulse = refPulse_reg;

    property p_float;
        @(posedge core_clk) disable iff (!nrst)
        (pins.colStrobeN && $past(pins.colStrobeN)) |=> !dqOe_reg;
    endproperty
    a_float: assert property (p_float) else $error("dq driven with column high");
    property p_cbr_inc;
        @(posedge core_clk) disable iff (!nrst)
        (rasFall && !pins.colStrobeN) |=> (refCnt_reg == $past(refCnt_reg) + 8'h01);
    endproperty
    a_cbr_inc: assert property (p_cbr_inc) else $error("refresh counter not advanced");
    property p_no_xfer_cbr;
        @(posedge core_clk) disable iff (!nrst)
        (rasFall && !pins.colStrobeN) |=> state_reg == vdt_pkg::VDT_REFRESH;
    endproperty
    a_no_xfer_cbr: assert property (p_no_xfer_cbr) else $error("refresh taken as transfer");
    property p_row_ref;
        @(posedge core_clk) disable iff (!nrst)
        (rasFall && pins.colStrobeN) |=> (refreshPulse && refreshRow == $past(pins.addr));
    endproperty
    a_row_ref: assert property (p_row_ref) else $error("access row not refreshed");
    property p_ptr_adv;
        @(posedge core_clk) disable iff (!nrst)
        (scRise && !loadPtr) |=> ptr == $past(ptr) + 8'h01;
    endproperty
    a_ptr_adv: assert property (p_ptr_adv) else $error("pointer did not advance");
    property p_dir;
        @(posedge core_clk) disable iff (!nrst)
        (state_reg == vdt_pkg::VDT_XFER && oeRise && xfer_reg == vdt_pkg::VDT_X_READ)
        |=> serOut_reg ##2 (serialDataOe == ~$past(pins.serialPortEnableN));
    endproperty
    a_dir: assert property (p_dir) else $error("read transfer left input mode");
    property p_pseudo;
        @(posedge core_clk) disable iff (!nrst)
        (state_reg == vdt_pkg::VDT_XFER && oeRise && xfer_reg != vdt_pkg::VDT_X_READ)
        |=> !serOut_reg;
    endproperty
    a_pseudo: assert property (p_pseudo) else $error("write kind left output mode");
    property p_tap;
        @(posedge core_clk) disable iff (!nrst)
        loadPtr |=> ptr == $past(pins.addr);
    endproperty
    a_tap: assert property (p_tap) else $error("tap not loaded");
    c_cbr: cover property (@(posedge core_clk) rasFall && !pins.colStrobeN);
    c_rx: cover property (@(posedge core_clk) doReadXfer);
    c_wx: cover property (@(posedge core_clk) doWriteXfer);
endmodule

// file: vdt_ctrl_model.sv
// Purpose: graphics controller model for the video dram transfer block
// Assumes: every pin level is held four core cycles, well past the sync
// Notes: slow but legal; released address and mask lines show the inverse of their last value
`timescale 1ns/1ps
module vdt_ctrl_model (
    input wire logic core_clk,
    output vdt_pkg::vdt_pins_s pins,
    output logic [3:0] writeData
);
    initial
    begin
        pins = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 4'h0, 4'h0};
        writeData = 4'h0;
    end
    task automatic step();
        repeat (4) @(posedge core_clk);
    endtask
    task automatic ras(input logic v);
        pins.rowStrobeN <= v;
        step();
    endtask
    task automatic cas(input logic v);
        pins.colStrobeN <= v;
        step();
    endtask
    task automatic oe(input logic v);
        pins.transferOutputEnableN <= v;
        step();
    endtask
    task automatic se(input logic v);
        pins.serialPortEnableN <= v;
        step();
    endtask
    // mode pins settle before the row strobe falls
    task automatic setup(input logic [7:0] a, input logic oeN, weN, seN, input logic [3:0] m);
        pins.addr <= a;
        pins.transferOutputEnableN <= oeN;
        pins.maskWriteEnableN <= weN;
        pins.serialPortEnableN <= seN;
        pins.maskDataIn <= m;
        step();
    endtask
    task automatic col(input logic [7:0] a);
        pins.addr <= a;
        step();
        cas(1'b0);
    endtask
    task automatic idle();
        pins.rowStrobeN <= 1'b1;
        pins.colStrobeN <= 1'b1;
        pins.transferOutputEnableN <= 1'b1;
        pins.maskWriteEnableN <= 1'b1;
        pins.addr <= ~pins.addr;
        pins.maskDataIn <= ~pins.maskDataIn;
        step();
    endtask
    // run lasts far under 4 ms, so no row decays
    task automatic refRow(input logic [7:0] a);
        setup(a, 1'b1, 1'b1, 1'b0, 4'h0);
        ras(1'b0);
        idle();
    endtask
    task automatic cbr(input logic oeN);
        cas(1'b0);
        setup(8'h33, oeN, 1'b1, 1'b0, 4'h0);
        ras(1'b0);
        idle();
    endtask
    // row strobe cycled under a held column strobe
    task automatic hidden();
        ras(1'b1);
        ras(1'b0);
    endtask
    task automatic wr(input logic [7:0] row, c, input logic [3:0] d, m);
        writeData <= d;
        setup(row, 1'b1, 1'b0, 1'b0, m);
        ras(1'b0);
        col(c);
        idle();
    endtask
    // serial clock stays low through every transfer
    // callers put a pseudo-write between read and write transfers
    task automatic xfer(input logic [7:0] row, tap, input logic weN, seN);
        setup(row, 1'b0, weN, seN, 4'h0);
        ras(1'b0);
        col(tap);
        oe(1'b1);
        idle();
    endtask
    // data set a step early so it never races the clock through the sync
    task automatic sclk(input logic [3:0] d);
        pins.serialDataIn <= d;
        step();
        pins.serialShiftClock <= 1'b1;
        step();
        pins.serialShiftClock <= 1'b0;
        step();
    endtask
endmodule

// file: vdt_top_tb_top.sv
// Purpose: self-checking bench for the video dram transfer block
// Assumes: controller model paces every pin change
// Notes: refresh rows logged from refreshPulse and compared as a list
`timescale 1ns/1ps
module vdt_top_tb_top;
    logic core_clk;
    logic nrst;
    vdt_pkg::vdt_pins_s ctrlPins;
    vdt_pkg::vdt_pins_s dutPins;
    logic [3:0] writeData;
    logic [3:0] maskDataOut;
    logic maskDataOe;
    logic [3:0] serialDataOut;
    logic serialDataOe;
    logic [7:0] refreshRow;
    logic refreshPulse;
    int n_errors = 0;
    int checks = 0;
    logic [7:0] refSeen[$];
    logic [7:0] refExp[$];
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // shared lines: the device wins while it drives
    always_comb
    begin
        dutPins = ctrlPins;
        if (maskDataOe === 1'b1)
            dutPins.maskDataIn = maskDataOut;
        if (serialDataOe === 1'b1)
            dutPins.serialDataIn = serialDataOut;
    end
    always @(posedge core_clk)
    begin
        if (refreshPulse === 1'b1)
            refSeen.push_back(refreshRow);
    end
    vdt_ctrl_model u_ctrl (.core_clk(core_clk), .pins(ctrlPins), .writeData(writeData));
    vdt_top u_dut (
        .core_clk(core_clk),
        .nrst(nrst),
        .pinsIn(dutPins),
        .writeDataIn(writeData),
        .maskDataOut(maskDataOut),
        .maskDataOe(maskDataOe),
        .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe),
        .refreshRow(refreshRow),
        .refreshPulse(refreshPulse)
    );
    task automatic end_of_test();
        if (n_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, got);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // read left open so a hidden refresh can follow
    task automatic rdOpen(input logic [7:0] row, c, input logic [3:0] exp);
        u_ctrl.setup(row, 1'b1, 1'b1, 1'b0, 4'h0);
        u_ctrl.ras(1'b0);
        u_ctrl.col(c);
        chk("dqFloat", 8'h00, 8'(maskDataOe));
        u_ctrl.oe(1'b0);
        chk("dqDrive", 8'h01, 8'(maskDataOe));
        chk("dqData", 8'(exp), 8'(maskDataOut));
    endtask
    task automatic rd(input logic [7:0] row, c, input logic [3:0] exp);
        rdOpen(row, c, exp);
        u_ctrl.idle();
        chk("dqRelease", 8'h00, 8'(maskDataOe));
    endtask
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        end_of_test();
    end
    initial
    begin
        nrst = 1'b0;
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk("serialOeReset", 8'h00, 8'(serialDataOe));
        u_ctrl.refRow(8'h5a);
        u_ctrl.refRow(8'hff);
        u_ctrl.cbr(1'b1);
        u_ctrl.cbr(1'b0);
        chk("serialOeCbr", 8'h00, 8'(serialDataOe));
        u_ctrl.wr(8'h10, 8'hfe, 4'hc, 4'hf);
        u_ctrl.wr(8'h10, 8'hfe, 4'h3, 4'h5);
        u_ctrl.wr(8'h10, 8'hff, 4'h5, 4'hf);
        u_ctrl.wr(8'h10, 8'h00, 4'h6, 4'hf);
        rdOpen(8'h10, 8'hfe, 4'h9);
        u_ctrl.hidden();
        chk("dqHoldOe", 8'h01, 8'(maskDataOe));
        chk("dqHoldData", 8'h09, 8'(maskDataOut));
        u_ctrl.cas(1'b1);
        chk("dqColRise", 8'h00, 8'(maskDataOe));
        u_ctrl.idle();
        refExp = '{8'h5a, 8'hff, 8'h00, 8'h01, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h02};
        chk("refreshCount", 8'(refExp.size()), 8'(refSeen.size()));
        foreach (refExp[i])
            chk("refreshRow", refExp[i], refSeen[i]);
        // read transfer, tap near the top to force the wrap
        u_ctrl.xfer(8'h10, 8'hfe, 1'b1, 1'b0);
        chk("serialOeRead", 8'h01, 8'(serialDataOe));
        u_ctrl.sclk(4'h0);
        chk("serialFirst", 8'h09, 8'(serialDataOut));
        u_ctrl.se(1'b1);
        chk("serialOeOff", 8'h00, 8'(serialDataOe));
        u_ctrl.sclk(4'h0);
        u_ctrl.se(1'b0);
        u_ctrl.sclk(4'h0);
        chk("serialWrap", 8'h06, 8'(serialDataOut));
        u_ctrl.xfer(8'h10, 8'hff, 1'b1, 1'b0);
        u_ctrl.sclk(4'h0);
        chk("serialRealTime", 8'h05, 8'(serialDataOut));
        u_ctrl.xfer(8'h77, 8'h00, 1'b0, 1'b1);
        u_ctrl.se(1'b0);
        chk("serialOePseudo", 8'h00, 8'(serialDataOe));
        u_ctrl.xfer(8'h21, 8'h40, 1'b0, 1'b0);
        chk("serialOeWrite", 8'h00, 8'(serialDataOe));
        rd(8'h21, 8'hfe, 4'h9);
        u_ctrl.sclk(4'ha);
        u_ctrl.sclk(4'hb);
        u_ctrl.xfer(8'h22, 8'h00, 1'b0, 1'b0);
        rd(8'h22, 8'h40, 4'ha);
        rd(8'h22, 8'h41, 4'hb);
        // mid-run reset: outputs clear, refresh counter restarts
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("serialDataReset", 8'h00, 8'(serialDataOut));
        chk("refreshRowReset", 8'h00, refreshRow);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        u_ctrl.cbr(1'b1);
        chk("refreshCbrReset", 8'h00, refreshRow);
        chk("serialOeReset2", 8'h00, 8'(serialDataOe));
        end_of_test();
    end
endmodule
